// *** hdl/pdc_pkg.sv ***
// Operation
// - Dial at 10 pps with rate select low, 20 pps with it high.
// - Make/break is 40/60 with ratio select low, 34/66 with it high.
// - Pulse output pulls low during break and is released during make.
// - Mute pulls low from predigital pause start until the last digit is sent.
// - Key feedback tone is 1 kHz at 10 pps and 2 kHz at 20 pps.
// - Hook/test low is off-hook; high or floating is on-hook/test.
// - A valid key is exactly one row with exactly one column.
// - Oscillator runs from key sense until dialing ends and for the first 300 ms on-hook, then standby.
// - On-hook holds rows and columns high and ignores the keypad.
// - Going off-hook resets timing, control and the pulse count.
// - Rows and columns scanned alternately; key accepted after 10 ms stable.
// - An accepted key is stored and dialed as one burst per digit.
// - On-hook while dialing sends the rest 100 times faster at 50/50.
// - Accelerated dialing ends within 300 ms unless on-hook came in a pause or interdigit time, which runs in full; then only memory stays alive.
// - Returning off-hook releases mute so speech reaches the line.
// - Star or pound as first key redials the stored number.
// - Any other first key clears memory, then stores and dials anew.
// - Pause and interdigit time 900 ms at 10 pps, 450 ms at 20 pps.
// - Memory is only cleared after at least 300 ms on-hook.
// - Mute stays on about 5 ms after the interdigit time that follows the final pulse.
package pdc_pkg;
  localparam int CLK_HZ          = 10_000_000;
  localparam int OSC_HZ          = 4_000;
  localparam int OSC_DIV         = CLK_HZ / OSC_HZ;
  localparam int PPS_LOW         = 10;
  localparam int PPS_HIGH        = 20;
  localparam int MAKE_PCT_LOW    = 40;
  localparam int MAKE_PCT_HIGH   = 34;
  localparam int ACCEL           = 100;
  localparam int PDP_MS_LOW      = 900;
  localparam int PDP_MS_HIGH     = 450;
  localparam int DEBOUNCE_MS     = 10;
  localparam int MUTE_HOLD_MS    = 5;
  localparam int ONHOOK_CLR_MS   = 300;
  localparam int TONE_HZ_LOW     = 1_000;
  localparam int TONE_HZ_HIGH    = 2_000;
  localparam int PERIOD_LOW      = OSC_HZ / PPS_LOW;
  localparam int PERIOD_HIGH     = OSC_HZ / PPS_HIGH;
  localparam int TMR_W           = 12;
  localparam logic [TMR_W-1:0] MAKE_LO_A = TMR_W'(PERIOD_LOW * MAKE_PCT_LOW / 100);
  localparam logic [TMR_W-1:0] MAKE_LO_B = TMR_W'(PERIOD_LOW * MAKE_PCT_HIGH / 100);
  localparam logic [TMR_W-1:0] MAKE_HI_A = TMR_W'(PERIOD_HIGH * MAKE_PCT_LOW / 100);
  localparam logic [TMR_W-1:0] MAKE_HI_B = TMR_W'(PERIOD_HIGH * MAKE_PCT_HIGH / 100);
  localparam logic [TMR_W-1:0] BRK_LO_A  = TMR_W'(PERIOD_LOW) - MAKE_LO_A;
  localparam logic [TMR_W-1:0] BRK_LO_B  = TMR_W'(PERIOD_LOW) - MAKE_LO_B;
  localparam logic [TMR_W-1:0] BRK_HI_A  = TMR_W'(PERIOD_HIGH) - MAKE_HI_A;
  localparam logic [TMR_W-1:0] BRK_HI_B  = TMR_W'(PERIOD_HIGH) - MAKE_HI_B;
  localparam logic [TMR_W-1:0] ACC_HALF_LO = TMR_W'(PERIOD_LOW / ACCEL / 2);
  localparam logic [TMR_W-1:0] ACC_HALF_HI = TMR_W'(PERIOD_HIGH / ACCEL / 2);
  localparam logic [TMR_W-1:0] ACC_GAP_TICKS = 12'h004;
  localparam logic [TMR_W-1:0] PDP_LO_TICKS  = TMR_W'(PDP_MS_LOW * OSC_HZ / 1000);
  localparam logic [TMR_W-1:0] PDP_HI_TICKS  = TMR_W'(PDP_MS_HIGH * OSC_HZ / 1000);
  localparam logic [TMR_W-1:0] MUTE_TICKS    = TMR_W'(MUTE_HOLD_MS * OSC_HZ / 1000);
  localparam logic [TMR_W-1:0] ONHOOK_TICKS  = TMR_W'(ONHOOK_CLR_MS * OSC_HZ / 1000);
  localparam logic [TMR_W-1:0] DEB_SCANS     = TMR_W'(DEBOUNCE_MS * OSC_HZ / 1000 / 2);
  localparam logic [1:0]       TONE_LO_HALF  = 2'(OSC_HZ / (2 * TONE_HZ_LOW));
  localparam logic [1:0]       TONE_HI_HALF  = 2'(OSC_HZ / (2 * TONE_HZ_HIGH));
  localparam int MEM_DEPTH = 16;
  localparam int PTR_W     = 5;
  localparam logic [3:0] KEY_ZERO  = 4'hA;
  localparam logic [3:0] KEY_STAR  = 4'hB;
  localparam logic [3:0] KEY_POUND = 4'hC;
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic        CTRL_TONE_RST = 1'b1;
  localparam logic [9:0]  SYNC_RST    = 10'h3FF;
  typedef enum logic [2:0] {
    PDC_IDLE  = 3'b000,
    PDC_PAUSE = 3'b001,
    PDC_BREAK = 3'b010,
    PDC_MAKE  = 3'b011,
    PDC_GAP   = 3'b100,
    PDC_HOLD  = 3'b101
  } pdc_state_t;
endpackage

// *** hdl/pdc_keyscan.sv ***
module pdc_keyscan (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       tick_in,
  input  wire logic       enable_in,
  input  wire logic [3:0] row_in,
  input  wire logic [2:0] col_in,
  output logic      [3:0] row_out,
  output logic      [3:0] row_oe_out,
  output logic      [2:0] col_out,
  output logic      [2:0] col_oe_out,
  output logic            busy_out,
  output logic            held_out,
  output logic            key_strobe_out,
  output logic      [3:0] key_code_out
);
  function automatic logic is_onehot(input logic [3:0] v);
    is_onehot = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction
  function automatic logic [1:0] onehot_idx(input logic [3:0] v);
    onehot_idx = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction

  logic                   scan_q;
  logic                   phase_q;
  logic [2:0]             col_cap_q;
  logic [3:0]             last_q;
  logic [pdc_pkg::TMR_W-1:0] cnt_q;
  logic                   acc_q;
  logic                   strobe_q;
  logic [3:0]             code_q;

  wire        sense     = ~&col_in;
  wire [3:0]  row_low   = ~row_in;
  wire [1:0]  ri        = onehot_idx(row_low);
  wire [1:0]  ci        = onehot_idx({1'b0, col_cap_q});
  wire        valid     = is_onehot(row_low) && is_onehot({1'b0, col_cap_q});
  wire [3:0]  digit     = 4'({2'b00, ri} * 4'h3 + {2'b00, ci} + 4'h1);
  wire [3:0]  code      = (ri != 2'h3) ? digit :
                          (ci == 2'h0) ? pdc_pkg::KEY_STAR :
                          (ci == 2'h1) ? pdc_pkg::KEY_ZERO : pdc_pkg::KEY_POUND;
  wire        eval      = scan_q && tick_in && phase_q;

  // Idle: rows held low so a press pulls a column; scan swaps the driven side
  assign row_out    = enable_in ? 4'h0 : 4'hF;
  assign row_oe_out = (!enable_in || !scan_q || !phase_q) ? 4'hF : 4'h0;
  assign col_out    = enable_in ? 3'h0 : 3'h7;
  assign col_oe_out = (!enable_in || (scan_q && phase_q)) ? 3'h7 : 3'h0;
  assign busy_out   = scan_q;
  assign held_out   = acc_q;
  assign key_strobe_out = strobe_q;
  assign key_code_out   = code_q;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      scan_q    <= 1'b0;
      phase_q   <= 1'b0;
      col_cap_q <= 3'h0;
      last_q    <= 4'h0;
      cnt_q     <= '0;
      acc_q     <= 1'b0;
      strobe_q  <= 1'b0;
      code_q    <= 4'h0;
    end else begin
      strobe_q <= 1'b0;
      if (!enable_in) begin
        scan_q  <= 1'b0;
        phase_q <= 1'b0;
        acc_q   <= 1'b0;
        cnt_q   <= '0;
      end else if (!scan_q) begin
        if (sense) begin
          scan_q  <= 1'b1;
          phase_q <= 1'b0;
        end
      end else if (tick_in) begin
        phase_q <= ~phase_q;
        if (!phase_q) begin
          col_cap_q <= ~col_in;
        end
      end
      if (enable_in && eval) begin
        if (valid && code == last_q) begin
          if (!acc_q && cnt_q == pdc_pkg::DEB_SCANS - 1'b1) begin
            acc_q    <= 1'b1;
            strobe_q <= 1'b1;
            code_q   <= code;
          end else if (!acc_q) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end else if (valid) begin
          last_q <= code;
          cnt_q  <= '0;
          acc_q  <= 1'b0;
        end else if (row_low == 4'h0 && col_cap_q == 3'h0) begin
          scan_q <= 1'b0;
          acc_q  <= 1'b0;
          cnt_q  <= '0;
        end else begin
          cnt_q <= '0;
        end
      end
    end
  end
endmodule

// *** hdl/pdc_top.sv ***
module pdc_top #(
  parameter int OSC_DIV = pdc_pkg::OSC_DIV
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        dial_rate_select_in,
  input  wire logic        make_break_select_in,
  input  wire logic        hook_test_select_in,
  input  wire logic [3:0]  row_in,
  input  wire logic [2:0]  col_in,
  output logic      [3:0]  row_out,
  output logic      [3:0]  row_oe_out,
  output logic      [2:0]  col_out,
  output logic      [2:0]  col_oe_out,
  output logic             line_pulse_out_n_out,
  output logic             line_pulse_oe_out,
  output logic             mute_out_n_out,
  output logic             mute_oe_out,
  output logic             key_tone_out,
  output logic             osc_run_out,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);
  localparam int TW = pdc_pkg::TMR_W;
  localparam int PW = pdc_pkg::PTR_W;

  // Pin synchronisers: stage one feeds stage two only
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= pdc_pkg::SYNC_RST;
      sync2_q <= pdc_pkg::SYNC_RST;
    end else begin
      sync1_q <= {make_break_select_in, dial_rate_select_in, hook_test_select_in,
                  col_in, row_in};
      sync2_q <= sync1_q;
    end
  end
  wire [3:0] row_s   = sync2_q[3:0];
  wire [2:0] col_s   = sync2_q[6:4];
  wire       on_hook = sync2_q[7];
  wire       rate_hi = sync2_q[8];
  wire       mbr_hi  = sync2_q[9];
  wire       offhook = ~on_hook;

  logic hook_prev_q;
  wire  offhook_edge = hook_prev_q && offhook;

  // Gated oscillator model: a tick every OSC_DIV clocks while running
  logic [11:0] div_q;
  logic        osc_run;
  wire         tick = osc_run && (div_q == 12'(OSC_DIV - 1));
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 12'h000;
    end else if (!osc_run || tick) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  logic       key_busy;
  logic       key_held;
  logic       key_strobe;
  logic [3:0] key_code;
  pdc_keyscan u_keyscan (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .tick_in        (tick),
    .enable_in      (offhook),
    .row_in         (row_s),
    .col_in         (col_s),
    .row_out        (row_out),
    .row_oe_out     (row_oe_out),
    .col_out        (col_out),
    .col_oe_out     (col_oe_out),
    .busy_out       (key_busy),
    .held_out       (key_held),
    .key_strobe_out (key_strobe),
    .key_code_out   (key_code)
  );

  // Number memory
  logic [3:0]    mem [pdc_pkg::MEM_DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] wr_d;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] rd_d;
  logic          first_q;
  logic          first_d;
  logic          mem_we;
  logic [PW-1:0] mem_wa;

  pdc_pkg::pdc_state_t st_q;
  pdc_pkg::pdc_state_t st_d;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] tmr_d;
  logic [3:0]    pcnt_q;
  logic [3:0]    pcnt_d;
  logic          fast_q;
  logic          fast_d;
  logic [TW-1:0] hook_cnt_q;
  logic          tone_en_q;

  wire is_dig     = (key_code >= 4'h1) && (key_code <= pdc_pkg::KEY_ZERO);
  wire is_redial  = (key_code == pdc_pkg::KEY_STAR) || (key_code == pdc_pkg::KEY_POUND);
  wire have_digit = (rd_q < wr_q);
  wire expire     = tick && (tmr_q == 12'h001);
  wire hook_done  = (hook_cnt_q >= pdc_pkg::ONHOOK_TICKS);
  wire [TW-1:0] make_t = fast_q ? (rate_hi ? pdc_pkg::ACC_HALF_HI : pdc_pkg::ACC_HALF_LO) :
                         rate_hi ? (mbr_hi ? pdc_pkg::MAKE_HI_B : pdc_pkg::MAKE_HI_A) :
                                   (mbr_hi ? pdc_pkg::MAKE_LO_B : pdc_pkg::MAKE_LO_A);
  wire [TW-1:0] brk_t  = fast_q ? (rate_hi ? pdc_pkg::ACC_HALF_HI : pdc_pkg::ACC_HALF_LO) :
                         rate_hi ? (mbr_hi ? pdc_pkg::BRK_HI_B : pdc_pkg::BRK_HI_A) :
                                   (mbr_hi ? pdc_pkg::BRK_LO_B : pdc_pkg::BRK_LO_A);
  wire [TW-1:0] gap_t  = fast_q ? pdc_pkg::ACC_GAP_TICKS :
                         rate_hi ? pdc_pkg::PDP_HI_TICKS : pdc_pkg::PDP_LO_TICKS;
  wire [3:0]    cur_digit = mem[rd_q[PW-2:0]];

  assign osc_run = (st_q != pdc_pkg::PDC_IDLE) || key_busy || (on_hook && !hook_done);

  always_comb begin
    st_d    = st_q;
    tmr_d   = (tick && tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    pcnt_d  = pcnt_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    first_d = first_q;
    fast_d  = fast_q || (on_hook && st_q != pdc_pkg::PDC_IDLE);
    mem_we  = 1'b0;
    mem_wa  = wr_q;
    case (st_q)
      pdc_pkg::PDC_IDLE: begin
        if (offhook && have_digit) begin
          st_d  = pdc_pkg::PDC_PAUSE;
          tmr_d = gap_t;
        end
      end
      pdc_pkg::PDC_PAUSE, pdc_pkg::PDC_GAP, pdc_pkg::PDC_HOLD: begin
        if (expire || (fast_q && st_q == pdc_pkg::PDC_HOLD)) begin
          if (have_digit && (st_q != pdc_pkg::PDC_HOLD || !fast_q)) begin
            st_d   = pdc_pkg::PDC_BREAK;
            tmr_d  = brk_t;
            pcnt_d = cur_digit;
          end else if (st_q == pdc_pkg::PDC_GAP && !fast_q) begin
            st_d  = pdc_pkg::PDC_HOLD;
            tmr_d = pdc_pkg::MUTE_TICKS;
          end else begin
            st_d   = pdc_pkg::PDC_IDLE;
            fast_d = 1'b0;
          end
        end
      end
      pdc_pkg::PDC_BREAK: begin
        if (expire) begin
          st_d  = pdc_pkg::PDC_MAKE;
          tmr_d = make_t;
        end
      end
      pdc_pkg::PDC_MAKE: begin
        if (expire && pcnt_q == 4'h1) begin
          st_d  = pdc_pkg::PDC_GAP;
          tmr_d = gap_t;
          rd_d  = rd_q + 1'b1;
        end else if (expire) begin
          st_d   = pdc_pkg::PDC_BREAK;
          tmr_d  = brk_t;
          pcnt_d = pcnt_q - 4'h1;
        end
      end
      default: begin
        st_d = pdc_pkg::PDC_IDLE;
      end
    endcase
    if (offhook_edge) begin
      st_d   = pdc_pkg::PDC_IDLE;
      tmr_d  = '0;
      pcnt_d = 4'h0;
      fast_d = 1'b0;
      rd_d   = wr_q;
    end else if (key_strobe && offhook) begin
      if (first_q && is_redial) begin
        first_d = 1'b0;
        rd_d    = '0;
      end else if (first_q && is_dig) begin
        first_d = 1'b0;
        mem_we  = 1'b1;
        mem_wa  = '0;
        wr_d    = PW'(1);
        rd_d    = '0;
      end else if (is_dig && wr_q < PW'(pdc_pkg::MEM_DEPTH)) begin
        mem_we = 1'b1;
        wr_d   = wr_q + 1'b1;
      end
    end
    if (on_hook && hook_done) begin
      first_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_wa[PW-2:0]] <= key_code;
    end
  end

  logic [1:0] tone_cnt_q;
  logic       tone_q;
  logic       pulse_oe_q;
  logic       mute_oe_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q        <= pdc_pkg::PDC_IDLE;
      tmr_q       <= '0;
      pcnt_q      <= 4'h0;
      rd_q        <= '0;
      wr_q        <= '0;
      first_q     <= 1'b1;
      fast_q      <= 1'b0;
      hook_prev_q <= 1'b1;
      pulse_oe_q  <= 1'b0;
      mute_oe_q   <= 1'b0;
    end else begin
      st_q        <= st_d;
      tmr_q       <= tmr_d;
      pcnt_q      <= pcnt_d;
      rd_q        <= rd_d;
      wr_q        <= wr_d;
      first_q     <= first_d;
      fast_q      <= fast_d;
      hook_prev_q <= on_hook;
      pulse_oe_q  <= (st_d == pdc_pkg::PDC_BREAK);
      mute_oe_q   <= (st_d != pdc_pkg::PDC_IDLE);
    end
  end

  // On-hook timer runs until the memory-clear time is reached
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hook_cnt_q <= '0;
    end else if (!on_hook) begin
      hook_cnt_q <= '0;
    end else if (tick && !hook_done) begin
      hook_cnt_q <= hook_cnt_q + 1'b1;
    end
  end

  wire [1:0] tone_half = rate_hi ? pdc_pkg::TONE_HI_HALF : pdc_pkg::TONE_LO_HALF;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tone_cnt_q <= 2'h0;
      tone_q     <= 1'b0;
    end else if (!(key_held && tone_en_q)) begin
      tone_cnt_q <= 2'h0;
      tone_q     <= 1'b0;
    end else if (tick && tone_cnt_q == tone_half - 2'h1) begin
      tone_cnt_q <= 2'h0;
      tone_q     <= ~tone_q;
    end else if (tick) begin
      tone_cnt_q <= tone_cnt_q + 2'h1;
    end
  end

  assign line_pulse_out_n_out = 1'b0;
  assign line_pulse_oe_out    = pulse_oe_q;
  assign mute_out_n_out       = 1'b0;
  assign mute_oe_out          = mute_oe_q;
  assign key_tone_out         = tone_q;
  assign osc_run_out          = osc_run;

  // AHB-Lite slave: zero wait states, OKAY only
  logic        dph_wr_q;
  logic [31:0] dph_addr_q;
  logic [31:0] rdata_q;
  wire         aph     = hsel_in && htrans_in[1] && hready_in;
  wire         sel_ctl = (haddr_in == pdc_pkg::ADDR_CTRL);
  wire         sel_sta = (haddr_in == pdc_pkg::ADDR_STATUS);
  wire [31:0]  status  = {17'h0, rd_q, wr_q, fast_q, offhook, st_q};
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 32'h0000_0000;
      rdata_q    <= 32'h0000_0000;
      tone_en_q  <= pdc_pkg::CTRL_TONE_RST;
    end else begin
      dph_wr_q <= aph && hwrite_in;
      if (aph) begin
        dph_addr_q <= haddr_in;
      end
      if (aph && !hwrite_in && sel_ctl) begin
        rdata_q <= {31'h0, tone_en_q};
      end else if (aph && !hwrite_in && sel_sta) begin
        rdata_q <= status;
      end else if (aph && !hwrite_in) begin
        rdata_q <= 32'h0000_0000;
      end
      if (dph_wr_q && dph_addr_q == pdc_pkg::ADDR_CTRL) begin
        tone_en_q <= hwdata_in[0];
      end
    end
  end
  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
endmodule

// *** tb/pdc_checker.sv ***
module pdc_checker #(
  parameter int OSC_DIV = 4
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       hook_test_select_in,
  input  wire logic [3:0] row_out,
  input  wire logic [3:0] row_oe_out,
  input  wire logic [2:0] col_out,
  input  wire logic [2:0] col_oe_out,
  input  wire logic       line_pulse_out_n_out,
  input  wire logic       line_pulse_oe_out,
  input  wire logic       mute_out_n_out,
  input  wire logic       mute_oe_out,
  input  wire logic       osc_run_out,
  input  wire logic       hreadyout_out,
  input  wire logic       hresp_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [15:0] brk_len_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in)
      brk_len_q <= 16'h0000;
    else
      brk_len_q <= line_pulse_oe_out ? brk_len_q + 16'h0001 : 16'h0000;
  end
  sequence s_on_hook;
    hook_test_select_in [*4];
  endsequence
  sequence s_off_hook_settled;
    $fell(hook_test_select_in) ##1 !hook_test_select_in [*3];
  endsequence
  AST_ONHOOK_KEYPAD: assert property (s_on_hook |-> row_oe_out == 4'hF && row_out == 4'hF
    && col_oe_out == 3'h7 && col_out == 3'h7) else $error("keypad not held high");
  AST_PULSE_MUTED: assert property (line_pulse_oe_out |-> mute_oe_out)
    else $error("break without mute");
  AST_PULSE_OSC: assert property (line_pulse_oe_out |-> osc_run_out)
    else $error("break with oscillator stopped");
  AST_OPEN_DRAIN: assert property (!line_pulse_out_n_out && !mute_out_n_out)
    else $error("open drain value not low");
  AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or not okay");
  AST_MUTE_OFFHOOK: assert property (s_off_hook_settled |=> !mute_oe_out)
    else $error("mute held after off hook");
  AST_BREAK_TICKS: assert property ($fell(line_pulse_oe_out) |->
    brk_len_q >= OSC_DIV && brk_len_q % OSC_DIV == 0) else $error("break not whole ticks");
  AST_MUTE_LEADS: assert property ($rose(mute_oe_out) |-> !line_pulse_oe_out [*8])
    else $error("break without pause");
endmodule

bind pdc_top pdc_checker #(.OSC_DIV(OSC_DIV)) pdc_checker_i (
  .clk_in(clk_in), .reset_in(reset_in), .hook_test_select_in(hook_test_select_in),
  .row_out(row_out), .row_oe_out(row_oe_out), .col_out(col_out), .col_oe_out(col_oe_out),
  .line_pulse_out_n_out(line_pulse_out_n_out), .line_pulse_oe_out(line_pulse_oe_out),
  .mute_out_n_out(mute_out_n_out), .mute_oe_out(mute_oe_out), .osc_run_out(osc_run_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out));

// *** tb/pdc_keypad_line.sv ***
module pdc_keypad_line (
  input  wire logic       clk_in,
  input  wire logic       press_in,
  input  wire logic [1:0] key_row_in,
  input  wire logic [1:0] key_col_in,
  input  wire logic       count_clear_in,
  input  wire logic [3:0] row_drive_in,
  input  wire logic [3:0] row_oe_in,
  input  wire logic [2:0] col_drive_in,
  input  wire logic [2:0] col_oe_in,
  input  wire logic       line_oe_in,
  input  wire logic       mute_oe_in,
  output logic      [3:0] row_level_out,
  output logic      [2:0] col_level_out,
  output logic            line_level_out,
  output logic            mute_level_out,
  output logic      [7:0] breaks_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic row_link;
  logic col_link;
  logic line_q;
  // One contact ties one row to one column; undriven pins pull up
  assign row_link = row_oe_in[key_row_in] ? row_drive_in[key_row_in] : 1'b1;
  assign col_link = col_oe_in[key_col_in] ? col_drive_in[key_col_in] : 1'b1;
  always_comb begin
    for (int i = 0; i < 4; i++)
      row_level_out[i] = row_oe_in[i] ? row_drive_in[i] :
        ((press_in && key_row_in == i) ? col_link : 1'b1);
    for (int j = 0; j < 3; j++)
      col_level_out[j] = col_oe_in[j] ? col_drive_in[j] :
        ((press_in && key_col_in == j) ? row_link : 1'b1);
  end
  assign line_level_out = !line_oe_in;
  assign mute_level_out = !mute_oe_in;
  always @(posedge clk_in) begin
    line_q <= line_oe_in;
    if (count_clear_in)
      breaks_out <= 8'h00;
    else if (line_oe_in && !line_q)
      breaks_out <= breaks_out + 8'h01;
  end
endmodule

// *** tb/pdc_top_test.sv ***
module pdc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  typedef struct {logic rt; logic mb; logic [3:0] dg;} pdc_row_t;
  pdc_row_t    rows [4] = '{'{1'b0, 1'b0, 4'h3}, '{1'b0, 1'b1, 4'h0},
                            '{1'b1, 1'b0, 4'h7}, '{1'b1, 1'b1, 4'h4}};
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic        rate     = 1'b0;
  logic        make_break_select      = 1'b0;
  logic        hook     = 1'b0;
  logic        press    = 1'b0;
  logic        clr      = 1'b1;
  logic [1:0]  krow     = 2'h0;
  logic [1:0]  kcol     = 2'h0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic [3:0]  row_o, row_oe, row_l;
  logic [2:0]  col_o, col_oe, col_l;
  logic        lp_oe, mu_oe, lp_n, mu_n, tone, osc, hrdy, hresp, line_l, mute_l;
  logic [31:0] hrdata, rd;
  logic [7:0]  breaks;
  int          failures    = 0;
  int          checks_done = 0;
  always #50 clk_in = ~clk_in;
  pdc_top #(.OSC_DIV(DIV)) pdc_top_i (
    .clk_in(clk_in), .reset_in(reset_in), .dial_rate_select_in(rate),
    .make_break_select_in(make_break_select), .hook_test_select_in(hook), .row_in(row_l), .col_in(col_l),
    .row_out(row_o), .row_oe_out(row_oe), .col_out(col_o), .col_oe_out(col_oe),
    .line_pulse_out_n_out(lp_n), .line_pulse_oe_out(lp_oe), .mute_out_n_out(mu_n),
    .mute_oe_out(mu_oe), .key_tone_out(tone), .osc_run_out(osc), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp));
  pdc_keypad_line pdc_keypad_line_i (
    .clk_in(clk_in), .press_in(press), .key_row_in(krow), .key_col_in(kcol),
    .count_clear_in(clr), .row_drive_in(row_o), .row_oe_in(row_oe), .col_drive_in(col_o),
    .col_oe_in(col_oe), .line_oe_in(lp_oe), .mute_oe_in(mu_oe), .row_level_out(row_l),
    .col_level_out(col_l), .line_level_out(line_l), .mute_level_out(mute_l),
    .breaks_out(breaks));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return lp_oe;
      1: return mu_oe;
      2: return osc;
      default: return tone;
    endcase
  endfunction
  task automatic await(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (pick(w) !== lvl && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= lim)
      check(n, 32'h0);
  endtask
  task automatic run_key(input logic [1:0] r, input logic [1:0] c, input int pulses,
                         input logic tone_on);
    int n, p, per, mk;
    per = pdc_pkg::OSC_HZ / (rate ? pdc_pkg::PPS_HIGH : pdc_pkg::PPS_LOW);
    mk = per * (make_break_select ? pdc_pkg::MAKE_PCT_HIGH : pdc_pkg::MAKE_PCT_LOW) / 100;
    clr <= 1'b1;
    krow <= r;
    kcol <= c;
    press <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    await(1, 1'b1, 800, n);
    check(osc, 1'b1);
    if (tone_on) begin
      await(3, 1'b1, 40, p);
      await(3, 1'b0, 40, n);
      check(n, rate ? DIV : 2 * DIV);
      p += n;
    end else begin
      repeat (40) @(posedge clk_in);
      p = 40;
      check(tone, 1'b0);
    end
    press <= 1'b0;
    await(0, 1'b1, 16000, n);
    check((p + n + DIV / 2) / DIV, (rate ? pdc_pkg::PDP_MS_HIGH : pdc_pkg::PDP_MS_LOW)
          * pdc_pkg::OSC_HZ / 1000);
    check(line_l, 1'b0);
    check(mute_l, 1'b0);
    await(0, 1'b0, 2000, n);
    check(n, (per - mk) * DIV);
    await(0, 1'b1, 2000, n);
    check(n, mk * DIV);
    hook <= 1'b1;
    // Accelerated dialing ends with mute release; the hook timer keeps the oscillator up
    await(1, 1'b0, 4800, n);
    check(breaks, pulses);
    repeat (5000) @(posedge clk_in);
    check(osc, 1'b0);
    hook <= 1'b0;
    repeat (20) @(posedge clk_in);
    check(mu_oe, 1'b0);
  endtask
  initial begin
    repeat (98000) @(posedge clk_in);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    bus(1'b0, pdc_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0001);
    bus(1'b0, pdc_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_0008);
    bus(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0008, 32'h0);
    check(rd, 32'h0000_0000);
    foreach (rows[i]) begin
      rate <= rows[i].rt;
      make_break_select <= rows[i].mb;
      repeat (4) @(posedge clk_in);
      if (rows[i].dg == 4'h0)
        run_key(2'h3, 2'h1, 10, 1'b1);
      else
        run_key(2'((rows[i].dg - 1) / 3), 2'((rows[i].dg - 1) % 3), rows[i].dg, 1'b1);
    end
    bus(1'b1, pdc_pkg::ADDR_CTRL, 32'h0);
    bus(1'b0, pdc_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0000);
    run_key(2'h3, 2'h0, 4, 1'b0);
    hook <= 1'b1;
    press <= 1'b1;
    repeat (5000) @(posedge clk_in);
    check(osc, 1'b0);
    check(mu_oe, 1'b0);
    bus(1'b0, pdc_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_0420);
    press <= 1'b0;
    report_and_stop();
  end
endmodule
